// ### bpl_pins.sv
// Board model for the five ports: pads, pull-ups, external levels.
// Assumes the pad struct of bpl_pkg; ext is what the board drives.
`timescale 1ns/1ps
module bpl_pins
  import bpl_pkg::*;
(
  input  wire bpl_pkg::bpl_pad_s [4:0] pad,  // Pad drive from ports
  input  wire logic [4:0][7:0]         ext,  // Board level, hi-Z pins
  output logic [4:0][7:0]              lvl   // Resolved wire level
);
  // Driver wins, then the pull-up, else the board holds the pin
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad[p].oe_n[b] === 1'b0) begin
          lvl[p][b] = pad[p].out[b];
        end else if (pad[p].pull[b] === 1'b1) begin
          lvl[p][b] = 1'b1;
        end else begin
          lvl[p][b] = ext[p][b];
        end
      end
    end
  end
endmodule

// ### bpl_pkg.sv
// Constants, types and the register map of the bidirectional port logic.
// Assumes a single 10 MHz clock domain and an AHB-Lite register bus.
package bpl_pkg;

  // ---------------------------------------------------------------
  // Port indices and widths
  // ---------------------------------------------------------------
  localparam int NPORT  = 5;            // Ports C, F, G, J, L
  localparam int PORT_C = 0;
  localparam int PORT_F = 1;
  localparam int PORT_G = 2;
  localparam int PORT_J = 3;
  localparam int PORT_L = 4;
  localparam int PORT_MISC = 5;         // Slot of the block's own registers

  // ---------------------------------------------------------------
  // Register map: haddr[7:4] picks the port, haddr[3:0] the register
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_CFG    = 4'h0;  // port_direction_config
  localparam logic [3:0] OFF_LATCH  = 4'h4;  // port_output_latch
  localparam logic [3:0] OFF_PIN    = 4'h8;  // port_pin_level
  localparam logic [3:0] OFF_STATUS = 4'h0;  // Misc slot: event status
  localparam logic [3:0] OFF_MASK   = 4'h4;  // Misc slot: interrupt mask
  localparam logic [3:0] OFF_CWAKE  = 4'h8;  // Misc slot: port C wake enable
  localparam logic [3:0] OFF_LWKEN  = 4'hC;  // Misc slot: port L wake enable

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int G_HALT_BIT  = 7;       // Port G latch: halt request
  localparam int G_IDLE_BIT  = 6;       // Port G latch: idle request
  localparam int G_DLY_BIT   = 7;       // Port G config: startup delay
  localparam int G_ALTSK_BIT = 6;       // Port G config: alt clock phase
  localparam int G_WDOG_PIN  = 1;
  localparam int G_EXTINT    = 0;
  localparam int G_TCAP      = 2;
  localparam int G_TIO       = 3;
  localparam int G_SOUT      = 4;
  localparam int G_SCLK      = 5;
  localparam int G_SIN       = 6;
  localparam int G_OSC       = 7;
  localparam int L_SDA       = 0;
  localparam int L_SCL       = 1;
  localparam int OPT_LOWV    = 7;       // Option byte fields
  localparam int OPT_CKS2    = 6;
  localparam int OPT_CKS1    = 4;
  localparam int OPT_CKS0    = 3;
  localparam int OPT_WDOG    = 2;       // Zero enables the watchdog pin
  localparam int OPT_HALT    = 1;       // Zero enables halt
  localparam int ST_WAKE_C   = 0;       // Status bit positions
  localparam int ST_WAKE_L   = 1;
  localparam int ST_WAKE_G7  = 2;
  localparam int ST_HALT     = 3;
  localparam int ST_IDLE     = 4;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CLK_CRYSTAL = 3'h0;  // Oscillator select codes
  localparam logic [2:0] CLK_RC      = 3'h1;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_ONES    = 8'hFF; // Port J and option byte
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // Bus phase tracker
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10,
    BUS_RDOUT = 2'b11
  } bpl_bus_e;

  // Pad drive of one port
  typedef struct packed {
    logic [7:0] out;                    // Level driven when enabled
    logic [7:0] oe_n;                   // Low while the pad drives
    logic [7:0] pull;                   // Weak pull-up on
  } bpl_pad_s;

  // Pin levels handed to the on-chip peripherals
  typedef struct packed {
    logic ser_in;
    logic serial_shift_clock;
    logic timer_io_pin;
    logic timer_capture_pin;
    logic ext_interrupt_pin;
    logic tw_sda;
    logic tw_scl;
  } bpl_alt_s;

endpackage

// ### bpl_port.sv
// Five 8-bit bidirectional ports with register, wake-up and pin logic.
// Assumes a single-slave AHB-Lite bus on hclk; pads resolve the wire.
//
// What this block does
// - Config/latch pick hi-Z, pull-up or push-pull
// - Each port has config, latch, pin registers
// - Port G latch bit 7 enters halt
// - Port G latch bit 6 enters idle
// - Port G latch bits 6, 7 read zero
// - Port G config bit 6 selects alt phase
// - Port G config bit 7 enables startup delay, with the RC clock option only
// - Watchdog option makes G1 pulled-up watchdog output
// - G6 is always a hi-Z input
// - Crystal option makes G7 the oscillator output
// - Otherwise G7 hi-Z input, rise wakes halt
// - Port J resets driving high
// - All port C and L pins wake
// - L0, L1 double as two-wire data, clock
// - Port G pins carry serial, timer, interrupt
// - Option bit 2 zero enables watchdog pin
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module bpl_port (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [4:0][7:0]      pin_in,
  output bpl_pkg::bpl_pad_s [4:0]   pad,
  input  wire logic [7:0]           option_byte,
  input  wire logic                 watchdog_out_pin,
  input  wire logic                 oscillator_out_pin,
  input  wire logic                 ser_out,
  input  wire logic                 ser_out_en,
  input  wire logic                 ser_clk_out,
  input  wire logic                 ser_clk_en,
  input  wire logic                 timer_out,
  input  wire logic                 timer_out_en,
  input  wire logic                 tw_enable,
  input  wire logic                 tw_sda_low,
  input  wire logic                 tw_scl_low,
  output bpl_pkg::bpl_alt_s         alt_in,
  output logic                      halt_mode,
  output logic                      idle_mode,
  output logic                      alt_shift_clock_phase,
  output logic                      startup_delay_enable,
  output logic                      low_voltage_input_select,
  output logic                      irq
);
  import bpl_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [4:0][7:0] cfg_reg,   cfg_next;     // Direction config
  logic [4:0][7:0] latch_reg, latch_next;   // Output latches
  logic [4:0][7:0] s1_reg, s2_reg, s3_reg;  // Pin synchroniser
  logic [4:0][7:0] lvl_reg,   lvl_next;     // Settled pin levels
  logic [4:0][7:0] prev_reg;                // Levels one cycle back
  logic [7:0]      status_reg, status_next; // Sticky events
  logic [7:0]      mask_reg,  mask_next;    // Interrupt mask
  logic [7:0]      cwk_reg,   cwk_next;     // Port C wake enable
  logic [7:0]      lwk_reg,   lwk_next;     // Port L wake enable
  logic [7:0]      opt_reg;                 // Option byte copy
  logic            halt_next, idle_next;
  bpl_pad_s [4:0]  pad_next;
  bpl_bus_e        bus_reg,   bus_next;
  logic [7:0]      addr_reg;                // Address of data phase
  logic [31:0]     rd_data;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire        accept   = hsel & htrans[1] & hready;
  wire        wr_en    = (bus_reg == BUS_WRITE);
  wire [3:0]  a_port   = addr_reg[7:4];
  wire [3:0]  a_off    = addr_reg[3:0];
  wire        misc_sel = (a_port == 4'(PORT_MISC));
  wire        wr_stat  = wr_en & misc_sel & (a_off == OFF_STATUS);
  wire        wr_mask  = wr_en & misc_sel & (a_off == OFF_MASK);
  wire        wr_cwk   = wr_en & misc_sel & (a_off == OFF_CWAKE);
  wire        wr_lwk   = wr_en & misc_sel & (a_off == OFF_LWKEN);
  wire [7:0]  wdat     = hwdata[7:0];
  wire        g_lat_wr = wr_en & (a_port == 4'(PORT_G))
                         & (a_off == OFF_LATCH);

  // Bus phase: writes take no wait, reads take one so the data flop
  // sees any write that finished in the cycle before
  always_comb begin
    case (bus_reg)
      BUS_READ: bus_next = BUS_RDOUT;
      BUS_IDLE, BUS_WRITE, BUS_RDOUT: begin
        if (accept) begin
          bus_next = hwrite ? BUS_WRITE : BUS_READ;
        end else begin
          bus_next = BUS_IDLE;
        end
      end
      default: bus_next = BUS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Option decode
  // ---------------------------------------------------------------
  wire [2:0] clk_sel  = {opt_reg[OPT_CKS2], opt_reg[OPT_CKS1],
                         opt_reg[OPT_CKS0]};
  wire       crystal  = (clk_sel == CLK_CRYSTAL);
  wire       rc_clock = (clk_sel == CLK_RC);
  wire       wdog_on  = ~opt_reg[OPT_WDOG];
  wire       halt_ok  = ~opt_reg[OPT_HALT];

  // ---------------------------------------------------------------
  // Port registers, one slice per port
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    wire hit    = wr_en & (a_port == 4'(p));
    wire cfg_w  = hit & (a_off == OFF_CFG);
    wire lat_w  = hit & (a_off == OFF_LATCH);
    // Halt and idle bits are commands, never stored
    wire [7:0] keep = (p == PORT_G) ? 8'h3F : 8'hFF;
    assign cfg_next[p]   = cfg_w ? wdat : cfg_reg[p];
    assign latch_next[p] = lat_w ? (wdat & keep) : latch_reg[p];
    // A change counts once the second and third stages agree
    for (genvar b = 0; b < 8; b++) begin : g_bit
      assign lvl_next[p][b] = (s2_reg[p][b] == s3_reg[p][b])
                              ? s2_reg[p][b] : lvl_reg[p][b];
    end
  end

  // Configuration and latches; port J comes up driving high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg   <= {RST_ZERO, RST_ONES, RST_ZERO, RST_ZERO, RST_ZERO};
      latch_reg <= {RST_ZERO, RST_ONES, RST_ZERO, RST_ZERO, RST_ZERO};
    end else begin
      cfg_reg   <= cfg_next;
      latch_reg <= latch_next;
    end
  end

  // Synchroniser starts at ones: a pin high at reset is no false rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg   <= '1;
      s2_reg   <= '1;
      s3_reg   <= '1;
      lvl_reg  <= '1;
      prev_reg <= '1;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      lvl_reg  <= lvl_next;
      prev_reg <= lvl_reg;
    end
  end

  // ---------------------------------------------------------------
  // Wake-up and events
  // ---------------------------------------------------------------
  wire [4:0][7:0] rise = lvl_reg & ~prev_reg;
  wire wake_c  = |(rise[PORT_C] & cwk_reg);
  wire wake_l  = |(rise[PORT_L] & lwk_reg);
  wire wake_g7 = rise[PORT_G][G_OSC] & ~crystal;
  wire wake    = wake_c | wake_l | wake_g7;
  wire halt_go = g_lat_wr & wdat[G_HALT_BIT] & halt_ok;
  wire idle_go = g_lat_wr & wdat[G_IDLE_BIT];

  // Entry wins over a wake in the same cycle
  assign halt_next = halt_go | (halt_mode & ~wake);
  assign idle_next = idle_go | (idle_mode & ~wake);

  // Status: a set in the clearing cycle survives
  wire [7:0] st_set = 8'((32'(wake_c)  << ST_WAKE_C)
                       | (32'(wake_l)  << ST_WAKE_L)
                       | (32'(wake_g7) << ST_WAKE_G7)
                       | (32'(halt_go) << ST_HALT)
                       | (32'(idle_go) << ST_IDLE));
  wire [7:0] st_clr = wr_stat ? wdat : RST_ZERO;
  assign status_next = st_set | (status_reg & ~st_clr);
  assign mask_next   = wr_mask ? wdat : mask_reg;
  // Reset leaves wake disabled, so absent port C pins stay quiet
  assign cwk_next    = wr_cwk ? wdat : cwk_reg;
  assign lwk_next    = wr_lwk ? wdat : lwk_reg;

  // Event state, masks and mode flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= RST_ZERO;
      mask_reg   <= RST_ZERO;
      cwk_reg    <= RST_ZERO;
      lwk_reg    <= RST_ZERO;
      halt_mode  <= 1'b0;
      idle_mode  <= 1'b0;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      cwk_reg    <= cwk_next;
      lwk_reg    <= lwk_next;
      halt_mode  <= halt_next;
      idle_mode  <= idle_next;
      irq        <= |(status_next & mask_next);
    end
  end

  // ---------------------------------------------------------------
  // Pad drive
  // ---------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pad_next[p].out  = latch_reg[p];
      pad_next[p].oe_n = ~cfg_reg[p];
      pad_next[p].pull = ~cfg_reg[p] & latch_reg[p];
    end
    // Serial, timer outputs take over their pins when enabled
    if (ser_out_en) begin
      pad_next[PORT_G].out[G_SOUT]  = ser_out;
      pad_next[PORT_G].oe_n[G_SOUT] = 1'b0;
    end
    if (ser_clk_en) begin
      pad_next[PORT_G].out[G_SCLK]  = ser_clk_out;
      pad_next[PORT_G].oe_n[G_SCLK] = 1'b0;
    end
    if (timer_out_en) begin
      pad_next[PORT_G].out[G_TIO]   = timer_out;
      pad_next[PORT_G].oe_n[G_TIO]  = 1'b0;
    end
    // Watchdog pin: pulled up, pulled low only while active
    if (wdog_on) begin
      pad_next[PORT_G].out[G_WDOG_PIN]  = 1'b0;
      pad_next[PORT_G].oe_n[G_WDOG_PIN] = watchdog_out_pin;
      pad_next[PORT_G].pull[G_WDOG_PIN] = 1'b1;
    end
    // G6 is an input whatever its bits say
    pad_next[PORT_G].out[G_SIN]  = 1'b0;
    pad_next[PORT_G].oe_n[G_SIN] = 1'b1;
    pad_next[PORT_G].pull[G_SIN] = 1'b0;
    // G7 follows the oscillator option only
    pad_next[PORT_G].out[G_OSC]  = crystal & oscillator_out_pin;
    pad_next[PORT_G].oe_n[G_OSC] = ~crystal;
    pad_next[PORT_G].pull[G_OSC] = 1'b0;
    // Two-wire bus pins are open drain, low drive only
    if (tw_enable) begin
      pad_next[PORT_L].out[L_SDA]  = 1'b0;
      pad_next[PORT_L].oe_n[L_SDA] = ~tw_sda_low;
      pad_next[PORT_L].pull[L_SDA] = 1'b0;
      pad_next[PORT_L].out[L_SCL]  = 1'b0;
      pad_next[PORT_L].oe_n[L_SCL] = ~tw_scl_low;
      pad_next[PORT_L].pull[L_SCL] = 1'b0;
    end
  end

  // Pads, peripheral levels and mode outputs, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad                      <= '{PORT_J: '{RST_ONES, RST_ZERO, RST_ZERO},
                                    default: '{RST_ZERO, RST_ONES, RST_ZERO}};
      alt_in                   <= '0;
      alt_shift_clock_phase    <= 1'b0;
      startup_delay_enable     <= 1'b0;
      low_voltage_input_select <= 1'b0;
      opt_reg                  <= RST_ONES;
    end else begin
      pad                      <= pad_next;
      alt_in.ser_in            <= lvl_reg[PORT_G][G_SIN];
      alt_in.serial_shift_clock<= lvl_reg[PORT_G][G_SCLK];
      alt_in.timer_io_pin      <= lvl_reg[PORT_G][G_TIO];
      alt_in.timer_capture_pin <= lvl_reg[PORT_G][G_TCAP];
      alt_in.ext_interrupt_pin <= lvl_reg[PORT_G][G_EXTINT];
      alt_in.tw_sda            <= lvl_reg[PORT_L][L_SDA];
      alt_in.tw_scl            <= lvl_reg[PORT_L][L_SCL];
      alt_shift_clock_phase    <= cfg_reg[PORT_G][G_ALTSK_BIT];
      startup_delay_enable     <= cfg_reg[PORT_G][G_DLY_BIT]
                                  & rc_clock;
      low_voltage_input_select <= opt_reg[OPT_LOWV] & tw_enable;
      opt_reg                  <= option_byte;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [2:0] rp = a_port[2:0];
  always_comb begin
    rd_data = RD_ZERO;
    if (misc_sel) begin
      case (a_off)
        OFF_STATUS: rd_data[7:0] = status_reg;
        OFF_MASK:   rd_data[7:0] = mask_reg;
        OFF_CWAKE:  rd_data[7:0] = cwk_reg;
        OFF_LWKEN:  rd_data[7:0] = lwk_reg;
        default:    rd_data = RD_ZERO;
      endcase
    end else if (a_port < 4'(NPORT)) begin
      case (a_off)
        OFF_CFG:   rd_data[7:0] = cfg_reg[rp];
        OFF_LATCH: rd_data[7:0] = latch_reg[rp];
        OFF_PIN:   rd_data[7:0] = lvl_reg[rp];
        default:   rd_data = RD_ZERO;
      endcase
    end
  end

  // Bus slave: one wait state on reads, OKAY always
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg   <= BUS_IDLE;
      addr_reg  <= RST_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= RD_ZERO;
    end else begin
      bus_reg   <= bus_next;
      hreadyout <= (bus_next != BUS_READ);
      hresp     <= 1'b0;
      if (accept) begin
        addr_reg <= haddr;
      end
      if (bus_reg == BUS_READ) begin
        hrdata <= rd_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_glat_write(int bitpos);
    g_lat_wr && wdat[bitpos];
  endsequence

  a_halt_entry: assert property (s_glat_write(G_HALT_BIT) ##0 halt_ok
    |=> halt_mode) else $error("halt not entered");
  a_idle_entry: assert property (s_glat_write(G_IDLE_BIT)
    |=> idle_mode) else $error("idle not entered");
  a_glatch_zero: assert property ((bus_reg == BUS_READ)
    && (a_port == 4'(PORT_G)) && (a_off == OFF_LATCH)
    |=> hreadyout && (hrdata[7:6] == 2'b00))
    else $error("port G latch bits 6, 7 not zero");
  a_alt_phase: assert property (wr_en && (a_port == 4'(PORT_G))
    && (a_off == OFF_CFG) && wdat[G_ALTSK_BIT]
    |=> ##1 alt_shift_clock_phase) else $error("alt phase not set");
  a_g6_input: assert property (pad[PORT_G].oe_n[G_SIN]
    && !pad[PORT_G].pull[G_SIN]) else $error("G6 not hi-Z input");
  a_g1_watchdog: assert property (wdog_on && $stable(opt_reg)
    |=> pad[PORT_G].pull[G_WDOG_PIN]) else $error("G1 pull missing");
  a_g7_option: assert property ($stable(opt_reg)
    |=> pad[PORT_G].oe_n[G_OSC] == !$past(crystal))
    else $error("G7 drive wrong for option");
  a_port_drive: assert property (##1
    pad[PORT_F].oe_n == ~$past(cfg_reg[PORT_F]))
    else $error("port F drive not following config");
  a_wake_status: assert property (wake_l
    |=> status_reg[ST_WAKE_L] && (irq || !mask_reg[ST_WAKE_L]))
    else $error("port L wake not flagged");

endmodule

// ### bpl_port_test.sv
// Self-checking bench for bpl_port over AHB-Lite with a board model.
// Assumes one 10 MHz clock and the register map of the hand-over.
`timescale 1ns/1ps
module bpl_port_test;
  import bpl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0] haddr, option_byte;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0][7:0] lvl, ext;          // Pin levels, board levels
  bpl_pad_s [4:0] pad;
  bpl_alt_s alt_in;
  logic wd, osc, so, so_en, sclk_o, sclk_en, t_o, t_en, tw, sda, scl;
  logic halt_mode, idle_mode, alt_ph, dly, lv;
  int error_cnt, compares;
  bpl_port bpl_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(lvl), .pad(pad),
    .option_byte(option_byte), .watchdog_out_pin(wd),
    .oscillator_out_pin(osc), .ser_out(so), .ser_out_en(so_en),
    .ser_clk_out(sclk_o), .ser_clk_en(sclk_en), .timer_out(t_o),
    .timer_out_en(t_en), .tw_enable(tw), .tw_sda_low(sda),
    .tw_scl_low(scl), .alt_in(alt_in), .halt_mode(halt_mode),
    .idle_mode(idle_mode), .alt_shift_clock_phase(alt_ph),
    .startup_delay_enable(dly), .low_voltage_input_select(lv),
    .irq(irq));
  bpl_pins bpl_pins_i (.pad(pad), .ext(ext), .lvl(lvl));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Wait for hready, bounded so a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 50) begin
      error_cnt++;
      conclude();
    end
  endtask
  // One single word transfer; read data taken at the closing edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0, "bus response");
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_modes();
    bus(8'h10, 1'b1, 32'h0000_000F);
    bus(8'h14, 1'b1, 32'h0000_0033);
    tick(8);
    chk(pad[1].oe_n, 8'hF0, "port F drive enables");
    chk(pad[1].pull, 8'h30, "port F pull-ups");
    chk(pad[1].out[3:0], 4'h3, "port F driven levels");
    bus(8'h18, 1'b0, 32'h0);
    chk(rd, 32'h0000_00B3, "port F pin read");
  endtask
  task automatic sc_power();
    bus(8'h54, 1'b1, 32'h0000_0002);  // Unmask port L wake only
    bus(8'h5C, 1'b1, 32'h0000_0001);
    bus(8'h24, 1'b1, 32'h0000_0080);
    tick(2);
    chk(halt_mode, 1'b1, "halt entry");
    bus(8'h24, 1'b0, 32'h0);
    chk(rd, 32'h0, "G latch top bits");
    ext[4][0] <= 1'b1;
    tick(10);
    chk(halt_mode, 1'b0, "wake from halt");
    chk(irq, 1'b1, "wake interrupt");
    bus(8'h50, 1'b0, 32'h0);
    chk(rd, 32'h0000_000A, "status bits");
    bus(8'h50, 1'b1, 32'h0000_000A);
    tick(3);
    chk(irq, 1'b0, "interrupt cleared");
    bus(8'h24, 1'b1, 32'h0000_0040);
    tick(2);
    chk(idle_mode, 1'b1, "idle entry");
    ext[4][0] <= 1'b0;
    tick(8);
    ext[4][0] <= 1'b1;
    tick(10);
    chk(idle_mode, 1'b0, "wake from idle");
  endtask
  task automatic sc_gcfg();
    bus(8'h20, 1'b1, 32'h0000_00C0);
    tick(3);
    chk(alt_ph, 1'b1, "alternate clock phase");
    chk(dly, 1'b1, "startup delay");
    chk({pad[2].oe_n[6], pad[2].pull[6]}, 2'b10, "G6 input");
    chk(alt_in, 7'h2A, "peripheral pin levels");
  endtask
  task automatic sc_pins();
    wd <= 1'b0;
    so <= 1'b1;
    so_en <= 1'b1;
    t_o <= 1'b0;
    t_en <= 1'b1;
    tick(4);
    chk({pad[2].oe_n[1], pad[2].pull[1]}, 2'b01, "watchdog pin");
    chk({pad[2].oe_n[4], pad[2].out[4]}, 2'b01, "serial out");
    chk({pad[2].oe_n[3], pad[2].out[3]}, 2'b00, "timer out");
    option_byte <= 8'h84;             // Crystal, watchdog off, low volt
    osc <= 1'b1;
    tw <= 1'b1;
    sda <= 1'b1;
    tick(6);
    chk({pad[2].oe_n[7], pad[2].out[7]}, 2'b01, "osc out");
    chk(pad[2].pull[1], 1'b0, "G1 plain port");
    chk(dly, 1'b0, "no delay on crystal");
    chk({pad[4].oe_n[1:0], pad[4].out[1:0]}, 4'h8, "two-wire pins");
    chk(lv, 1'b1, "low voltage select");
  endtask
  // ---------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, so, so_en, sclk_o, sclk_en, t_o, t_en} = '0;
    {tw, sda, scl, osc, htrans, haddr, hsize, hwdata} = '0;
    wd = 1'b1;
    option_byte = 8'h08;              // RC clock, watchdog and halt on
    ext = {5{8'hA4}};
    error_cnt = 0;
    compares = 0;
    tick(3);
    chk({pad[3].oe_n, pad[3].out}, 16'h00FF, "port J in reset");
    tick(1);
    hresetn <= 1'b1;
    tick(1);
    chk({pad[3].oe_n, pad[3].out}, 16'h00FF, "port J reset");
    bus(8'h58, 1'b1, 32'h0);
    sc_modes();
    sc_power();
    sc_gcfg();
    sc_pins();
    conclude();
  end
endmodule
